// ==== bench/page_mode_dram_cycle_timing_bench.sv ====
`timescale 1ns/1ns
`default_nettype none

module page_mode_dram_cycle_timing_bench;
  import pmdct_pkg::*;

  logic        mclk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        req_valid_i = 1'b0;
  pmdct_req_s  req_i = '0;
  logic        req_ready_o, rsp_valid_o, rsp_data_o, init_done_o, dram_dout_i;
  pmdct_pins_s dram_o;
  logic [15:0] ref_cnt, ras_cnt, viol;
  int          n_fail = 0;
  int          check_count = 0;
  logic        got_q[$];
  logic [8:0]  rw [4] = '{9'h000, 9'h1ff, 9'h0aa, 9'h155};

  always #5 mclk_i = ~mclk_i;

  pmdct_ctrl #(.INIT_PAUSE_CYC(14'h0014)) pmdct_ctrl_inst (
    .mclk_i(mclk_i), .rst_i(rst_i), .req_valid_i(req_valid_i), .req_i(req_i),
    .req_ready_o(req_ready_o), .rsp_valid_o(rsp_valid_o), .rsp_data_o(rsp_data_o),
    .init_done_o(init_done_o), .dram_o(dram_o), .dram_dout_i(dram_dout_i));

  // Pause of 20 cycles
  pmdct_dram_model #(.INIT_NS(20 * CLK_NS)) pmdct_dram_model_inst (
    .pins_i(dram_o), .dout_o(dram_dout_i), .ref_cnt_o(ref_cnt), .ras_cnt_o(ras_cnt), .viol_o(viol));

  always @(posedge mclk_i) if (rsp_valid_o === 1'b1) got_q.push_back(rsp_data_o);

  ////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic close_out;
    $display("counts: %0d checks, %0d mismatches", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Leaves valid high; caller follows with another request or idle
  task automatic req(input pmdct_op_e op, input logic tw, pg, input logic [8:0] r, c, input logic d);
    int n;
    n = 0;
    req_valid_i <= 1'b1;
    req_i <= '{op: op, test_wr: tw, page: pg, row: r, col: c, din: d};
    do begin
      @(posedge mclk_i);
      n++;
    end while (req_ready_o !== 1'b1 && n < 3000);
    check(n < 3000, 1);
  endtask

  task automatic idle_wait(input int n);
    int k;
    k = 0;
    req_valid_i <= 1'b0;
    while (got_q.size() < n && k < 100) begin
      @(posedge mclk_i);
      k++;
    end
    repeat (2) @(posedge mclk_i);
    check(got_q.size(), n);
  endtask

  task automatic t_init;
    int k;
    k = 0;
    while (init_done_o !== 1'b1 && k < 2000) begin
      @(posedge mclk_i);
      k++;
    end
    // Done rises as the last refresh starts; let its row strobe fall
    repeat (4) @(posedge mclk_i);
    check(init_done_o, 1);
    check(ref_cnt, 8);
    $display("test init done");
  endtask

  task automatic t_page;
    logic [15:0] r0;
    r0 = ras_cnt;
    req(OP_WRITE, 0, 1, 9'h1ff, 9'h000, 1);
    req(OP_WRITE, 0, 1, 9'h1ff, 9'h1ff, 0);
    req(OP_RMW, 0, 1, 9'h1ff, 9'h000, 0);
    req(OP_READ, 0, 0, 9'h1ff, 9'h000, 1);
    idle_wait(2);
    check(got_q.pop_front(), 1);
    check(got_q.pop_front(), 0);
    check(ras_cnt - r0, 1);
    $display("test page done");
  endtask

  task automatic t_wr_rd;
    for (int i = 0; i < 4; i++) req(OP_WRITE, 0, 0, rw[i], rw[3-i], i[0]);
    for (int i = 0; i < 4; i++) req(OP_READ, 0, 0, rw[i], rw[3-i], !i[0]);
    idle_wait(4);
    for (int i = 0; i < 4; i++) check(got_q.pop_front(), i[0]);
    $display("test write read done");
  endtask

  task automatic t_test;
    logic [15:0] k;
    req(OP_TEST, 1, 0, 9'h000, 9'h0c3, 1);
    k = ref_cnt;
    req(OP_READ, 0, 0, {1'b1, k[7:0]}, 9'h0c3, 0);
    // Next counter row holds a one, so the test read proves the step
    req(OP_WRITE, 0, 0, {1'b1, k[7:0] + 8'h01}, 9'h0c3, 1);
    req(OP_TEST, 0, 0, 9'h000, 9'h0c3, 0);
    idle_wait(2);
    check(got_q.pop_front(), 1);
    check(got_q.pop_front(), 1);
    $display("test counter done");
  endtask

  task automatic t_refresh;
    logic [15:0] k;
    k = ref_cnt;
    repeat (3 * REFRESH_PERIOD_NS / REFRESH_ROWS / CLK_NS) @(posedge mclk_i);
    check(ref_cnt - k >= 2, 1);
    $display("test refresh done");
  endtask

  initial begin
    @(posedge mclk_i);
    @(posedge mclk_i);
    check(dram_o, PINS_IDLE);
    check(init_done_o, 0);
    rst_i <= 1'b0;
    t_init();
    t_page();
    t_wr_rd();
    t_test();
    t_refresh();
    check(viol, 0);
    close_out();
  end

  initial begin
    repeat (30000) @(posedge mclk_i);
    n_fail++;
    close_out();
  end
endmodule

`default_nettype wire

// ==== bench/pmdct_dram_model.sv ====
`timescale 1ns/1ns
`default_nettype none

module pmdct_dram_model
  import pmdct_pkg::*;
#(
  parameter int INIT_NS = INIT_PAUSE_NS
) (
  // Memory pins
  input  wire pmdct_pins_s pins_i,
  output logic             dout_o,
  // Counts
  output logic [15:0]      ref_cnt_o,
  output logic [15:0]      ras_cnt_o,
  output logic [15:0]      viol_o
);
  bit         mem [0:262143];
  logic [7:0] rcnt = 8'h00;
  logic [8:0] row;
  logic [8:0] col;
  logic       rdat = 1'b0;
  bit         cbr;
  bit         tst;
  bit         rd;
  bit         rv;
  int         ncas;
  time        trf = 0, trr = 0, tcf = 0, tcr = 0, ttst = 0, tv = 0;

  initial {ref_cnt_o, ras_cnt_o, viol_o} = '0;

  ////////////////////////////////////////
  always @(negedge pins_i.ras_n) begin
    if (ras_cnt_o == 0 && $time < INIT_NS) viol_o++;
    if (ras_cnt_o != 0 && $time - trf < RANDOM_CYCLE_TIME_NS) viol_o++;
    trf = $time;
    ras_cnt_o++;
    ncas = 0;
    cbr = !pins_i.cas_n;
    if (cbr) begin
      if ($time - tcf < REFRESH_COLUMN_SETUP_NS) viol_o++;
      row = {1'b1, rcnt};
      rcnt++;
      ref_cnt_o++;
    end else begin
      row = pins_i.addr;
    end
  end

  always @(posedge pins_i.ras_n) begin
    if (tst && ($time - trf < COUNTER_TEST_ROW_PULSE_NS || $time - trf > ROW_PULSE_MAX_NS)) viol_o++;
    trr = $time;
    tst = 0;
  end

  always @(negedge pins_i.cas_n) begin
    if ($time - trr < ROW_PRECHARGE_TO_COLUMN_NS) viol_o++;
    if (!pins_i.ras_n) begin
      if (cbr) begin
        if ($time - tcr < COUNTER_TEST_COL_PRECHARGE_NS || (ttst != 0 && trf - ttst < COUNTER_TEST_CYCLE_TIME_NS)) viol_o++;
        ttst = trf;
        tst = 1;
      end else begin
        // access only after eight row cycles
        if (ras_cnt_o < 9) viol_o++;
        if (ncas != 0 && ($time - tcf < PAGE_CYCLE_TIME_NS || $time - tcr < PAGE_COLUMN_PRECHARGE_NS)) viol_o++;
      end
      col = pins_i.addr;
      ncas++;
      rdat = mem[{row, col}];
      rv = 1;
      // valid after later of both accesses
      tv = (($time + COLUMN_ACCESS_TIME_NS > trf + ROW_ACCESS_TIME_NS) ?
            $time + COLUMN_ACCESS_TIME_NS : trf + ROW_ACCESS_TIME_NS) - 1;
      rd = pins_i.we_n;
      if (!rd) mem[{row, col}] = pins_i.din;
    end
    tcf = $time;
  end

  always @(posedge pins_i.cas_n) begin
    if (cbr && !tst && !pins_i.ras_n && $time - trf < REFRESH_COLUMN_HOLD_NS) viol_o++;
    tcr = $time;
  end

  always @(negedge pins_i.we_n) begin
    if (!pins_i.ras_n && !pins_i.cas_n && rd) begin
      if ($time - tcf < COLUMN_TO_WRITE_DELAY_NS) rv = 0;
      mem[{row, col}] = pins_i.din;
    end
  end

  always #1 dout_o = (rd && rv && !pins_i.cas_n && $time >= tv) ? rdat : !rdat;
endmodule

`default_nettype wire

// ==== verilog/pmdct_ctrl.sv ====
`timescale 1ns/1ns
`default_nettype none

// Notes on behaviour
// - pause after reset, then eight refreshes
// - one refresh per interval, 256 per period
// - row cycles spaced by random cycle time
// - page column precharge and page cycle
// - column strobe leads row strobe on refresh
// - column strobe held after refresh row fall
// - column strobe high after row rise
// - counter test row pulse bounded
// - counter test spacing and column precharge
// - write-select high reads, low writes
// - row then column address on shared pins
module pmdct_ctrl
  import pmdct_pkg::*;
#(
  parameter logic [13:0] INIT_PAUSE_CYC = INIT_PAUSE_DEF_CYC
) (
  // Clock and reset
  input  wire logic        mclk_i,
  input  wire logic        rst_i,
  // User request
  input  wire logic        req_valid_i,
  input  wire pmdct_req_s  req_i,
  output logic             req_ready_o,
  // User response
  output logic             rsp_valid_o,
  output logic             rsp_data_o,
  output logic             init_done_o,
  // Memory pins
  output pmdct_pins_s      dram_o,
  input  wire logic        dram_dout_i
);

  pmdct_state_e st_r,   st_nxt;
  pmdct_req_s   cur_r,  cur_nxt;
  pmdct_pins_s  pin_r,  pin_nxt;
  pmdct_cyc_t   cyc_r,  cyc_nxt;
  logic [3:0]   left_r, left_nxt;
  logic         pend_r, pend_nxt;
  logic         rd_r,   rd_nxt;
  logic         vld_r,  vld_nxt;
  logic         ph_load;
  pmdct_ph_t    ph_val;
  logic         ph_done;
  logic         ref_tick;
  logic         pause_done;
  logic         end_col;
  logic         hit;
  logic         ready;
  pmdct_cyc_t   rc_min;
  pmdct_cyc_t   ras_min;

  ////////////////////////////////////////////////////////////////////////////
  // Timers

  pmdct_timer #(.W(5), .RST_VAL(5'h00)) u_phase (
    .mclk_i  (mclk_i),
    .rst_i   (rst_i),
    .load_i  (ph_load),
    .value_i (ph_val),
    .done_o  (ph_done)
  );

  pmdct_timer #(.W(11), .RST_VAL(REF_INT_CYC)) u_refresh (
    .mclk_i  (mclk_i),
    .rst_i   (rst_i),
    .load_i  (ref_tick),
    .value_i (REF_INT_CYC),
    .done_o  (ref_tick)
  );

  pmdct_timer #(.W(14), .RST_VAL(INIT_PAUSE_CYC)) u_pause (
    .mclk_i  (mclk_i),
    .rst_i   (rst_i),
    .load_i  (1'b0),
    .value_i (14'h0000),
    .done_o  (pause_done)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer

  // test cycles need the longer spacing
  assign rc_min  = (cur_r.op == OP_TEST) ? RTC_CYC : RC_CYC;
  assign ras_min = (cur_r.op == OP_TEST) ? TRAS_CYC : RAS_CYC;
  // same-row follow-on stays in page, row pulse kept short
  assign hit = cur_r.page && (cur_r.op != OP_TEST) && req_valid_i && (req_i.op != OP_TEST) &&
               (req_i.row == cur_r.row) && !pend_r && (cyc_r < PAGE_LIMIT_CYC);

  always_comb begin
    st_nxt   = st_r;
    cur_nxt  = cur_r;
    pin_nxt  = pin_r;
    cyc_nxt  = (cyc_r == CYC_SAT) ? cyc_r : cyc_r + 10'h001;
    left_nxt = left_r;
    // a tick in the clearing cycle is kept
    pend_nxt = pend_r | ref_tick;
    rd_nxt   = rd_r;
    vld_nxt  = 1'b0;
    ph_load  = 1'b0;
    ph_val   = 5'h00;
    end_col  = 1'b0;
    ready    = 1'b0;
    case (st_r)
      S_INIT: begin
        if (pause_done) begin
          st_nxt = S_IDLE;
        end
      end
      S_IDLE: begin
        if (pend_r || (left_r != 4'h0)) begin
          pend_nxt  = ref_tick;
          left_nxt  = (left_r != 4'h0) ? left_r - 4'h1 : left_r;
          cur_nxt   = '0;
          pin_nxt.cas_n = 1'b0;
          st_nxt    = S_FCS;
          ph_load   = 1'b1;
          ph_val    = FCS_CYC;
        end else if (req_valid_i) begin
          ready   = 1'b1;
          cur_nxt = req_i;
          ph_load = 1'b1;
          if (req_i.op == OP_TEST) begin
            // counter test also starts column first
            pin_nxt.cas_n = 1'b0;
            st_nxt  = S_FCS;
            ph_val  = FCS_CYC;
          end else begin
            pin_nxt.ras_n = 1'b0;
            pin_nxt.addr  = req_i.row;
            cyc_nxt = 10'h000;
            st_nxt  = S_ROW;
            ph_val  = RAH_CYC;
          end
        end
      end
      S_ROW: begin
        if (ph_done) begin
          pin_nxt.addr = cur_r.col;
          // early write sets write-select before column strobe
          pin_nxt.we_n = (cur_r.op != OP_WRITE);
          pin_nxt.din  = cur_r.din;
          st_nxt  = S_ASC;
          ph_load = 1'b1;
          ph_val  = ASC_CYC;
        end
      end
      S_ASC: begin
        if (ph_done) begin
          pin_nxt.cas_n = 1'b0;
          st_nxt  = S_COL;
          ph_load = 1'b1;
          ph_val  = COL_CYC;
        end
      end
      S_COL: begin
        if (ph_done) begin
          // column span covers row and column access
          if (cur_r.op == OP_RMW) begin
            // data read, then write-select falls late
            rd_nxt  = dram_dout_i;
            vld_nxt = 1'b1;
            pin_nxt.we_n = 1'b0;
            st_nxt  = S_WR;
            ph_load = 1'b1;
            ph_val  = CWL_CYC;
          end else begin
            // data out taken only on reads and counter test reads
            if ((cur_r.op == OP_READ) || ((cur_r.op == OP_TEST) && !cur_r.test_wr)) begin
              rd_nxt  = dram_dout_i;
              vld_nxt = 1'b1;
            end
            end_col = 1'b1;
          end
        end
      end
      S_WR: begin
        if (ph_done) begin
          end_col = 1'b1;
        end
      end
      S_CP: begin
        if (ph_done) begin
          pin_nxt.cas_n = 1'b0;
          st_nxt  = S_COL;
          ph_load = 1'b1;
          ph_val  = COL_CYC;
        end
      end
      S_RASW: begin
        if (cyc_r >= ras_min - 10'h001) begin
          pin_nxt.ras_n = 1'b1;
          st_nxt  = S_PRE;
          ph_load = 1'b1;
          ph_val  = PRE_CYC;
        end
      end
      S_PRE: begin
        // precharge and full cycle both met
        // precharge also delays next column strobe
        if (ph_done && (cyc_r >= rc_min - 10'h001)) begin
          st_nxt = S_IDLE;
        end
      end
      S_FCS: begin
        if (ph_done) begin
          pin_nxt.ras_n = 1'b0;
          cyc_nxt = 10'h000;
          st_nxt  = S_FCH;
          ph_load = 1'b1;
          ph_val  = FCH_CYC;
        end
      end
      S_FCH: begin
        // column strobe held after row fall
        if (ph_done) begin
          pin_nxt.cas_n = 1'b1;
          if (cur_r.op == OP_TEST) begin
            pin_nxt.addr = cur_r.col;
            pin_nxt.we_n = !cur_r.test_wr;
            pin_nxt.din  = cur_r.din;
            st_nxt  = S_CPT;
            ph_load = 1'b1;
            ph_val  = CPT_CYC;
          end else begin
            st_nxt = S_RASW;
          end
        end
      end
      S_CPT: begin
        if (ph_done) begin
          pin_nxt.cas_n = 1'b0;
          st_nxt  = S_COL;
          ph_load = 1'b1;
          ph_val  = COL_CYC;
        end
      end
      default: begin
        st_nxt  = S_IDLE;
        pin_nxt = PINS_IDLE;
      end
    endcase
    if (end_col) begin
      pin_nxt.cas_n = 1'b1;
      pin_nxt.we_n  = 1'b1;
      if (hit) begin
        ready   = 1'b1;
        cur_nxt = req_i;
        pin_nxt.addr = req_i.col;
        pin_nxt.we_n = (req_i.op != OP_WRITE);
        pin_nxt.din  = req_i.din;
        st_nxt  = S_CP;
        ph_load = 1'b1;
        ph_val  = CP_CYC;
      end else begin
        st_nxt = S_RASW;
      end
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      st_r   <= S_INIT;
      cur_r  <= '0;
      pin_r  <= PINS_IDLE;
      cyc_r  <= CYC_SAT;
      left_r <= INIT_RAS_CNT;
      pend_r <= 1'b0;
      rd_r   <= 1'b0;
      vld_r  <= 1'b0;
    end else begin
      st_r   <= st_nxt;
      cur_r  <= cur_nxt;
      pin_r  <= pin_nxt;
      cyc_r  <= cyc_nxt;
      left_r <= left_nxt;
      pend_r <= pend_nxt;
      rd_r   <= rd_nxt;
      vld_r  <= vld_nxt;
    end
  end

  assign req_ready_o = ready;
  assign rsp_valid_o = vld_r;
  assign rsp_data_o  = rd_r;
  assign init_done_o = (left_r == 4'h0) && (st_r != S_INIT);
  assign dram_o      = pin_r;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  logic [9:0]  fall_gap_r;
  logic [9:0]  low_cnt_r;
  logic [11:0] ref_gap_r;
  logic [3:0]  falls_r;
  logic        ras_fall;
  logic        cbr_fall;
  logic        ras_q_r;

  // Row strobe level one cycle back, idle level after reset
  assign ras_fall = ras_q_r && !pin_r.ras_n;
  assign cbr_fall = ras_fall && !pin_r.cas_n;

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      fall_gap_r <= 10'h3ff;
      low_cnt_r  <= 10'h000;
      ref_gap_r  <= 12'h000;
      falls_r    <= 4'h0;
      ras_q_r    <= 1'b1;
    end else begin
      fall_gap_r <= ras_fall ? 10'h001 : ((fall_gap_r == 10'h3ff) ? fall_gap_r : fall_gap_r + 10'h001);
      low_cnt_r  <= pin_r.ras_n ? 10'h000 : low_cnt_r + 10'h001;
      ref_gap_r  <= cbr_fall ? 12'h000 : ((ref_gap_r == 12'hfff) ? ref_gap_r : ref_gap_r + 12'h001);
      falls_r    <= (ras_fall && (falls_r != 4'hf)) ? falls_r + 4'h1 : falls_r;
      ras_q_r    <= pin_r.ras_n;
    end
  end

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);

  property p_init_refresh;
    req_ready_o |-> (falls_r >= INIT_RAS_CNT);
  endproperty
  a_init_refresh: assert property (p_init_refresh) else $error("access before init refreshes");

  property p_refresh_gap;
    init_done_o |-> (ref_gap_r <= 12'(REF_INT_CYC) + 12'h040);
  endproperty
  a_refresh_gap: assert property (p_refresh_gap) else $error("refresh interval exceeded");

  property p_early_write;
    $fell(pin_r.cas_n) && !pin_r.ras_n && (cur_r.op == OP_WRITE) |-> !pin_r.we_n && $past(!pin_r.we_n);
  endproperty
  a_early_write: assert property (p_early_write) else $error("early write not set up");

  property p_rmw_late;
    $fell(pin_r.we_n) && (cur_r.op == OP_RMW) |-> !pin_r.cas_n && $past(!pin_r.cas_n, 2) && rsp_valid_o;
  endproperty
  a_rmw_late: assert property (p_rmw_late) else $error("read-modify-write write too early");

  property p_cycle_space;
    ras_fall |-> (fall_gap_r >= RC_CYC);
  endproperty
  a_cycle_space: assert property (p_cycle_space) else $error("row cycle too short");

  property p_page_precharge;
    $rose(pin_r.cas_n) && !pin_r.ras_n |-> pin_r.cas_n [*4];
  endproperty
  a_page_precharge: assert property (p_page_precharge) else $error("column precharge too short");

  property p_cbr_setup;
    cbr_fall |-> $past(!pin_r.cas_n) && $past(!pin_r.cas_n, 2);
  endproperty
  a_cbr_setup: assert property (p_cbr_setup) else $error("refresh column setup short");

  property p_cbr_hold;
    cbr_fall |-> !pin_r.cas_n [*2];
  endproperty
  a_cbr_hold: assert property (p_cbr_hold) else $error("refresh column hold short");

  property p_row_to_col;
    $rose(pin_r.ras_n) |-> pin_r.cas_n [*2];
  endproperty
  a_row_to_col: assert property (p_row_to_col) else $error("column strobe too soon after row rise");

  property p_test_pulse;
    $rose(pin_r.ras_n) && (cur_r.op == OP_TEST) |-> ($past(low_cnt_r) >= TRAS_CYC - 10'h001) &&
                                                   ($past(low_cnt_r) < RAS_MAX_CYC);
  endproperty
  a_test_pulse: assert property (p_test_pulse) else $error("counter test row pulse out of range");

  property p_test_cpt;
    $rose(pin_r.cas_n) && (st_r == S_CPT) |-> pin_r.cas_n [*5];
  endproperty
  a_test_cpt: assert property (p_test_cpt) else $error("counter test column precharge short");

  property p_read_we;
    $fell(pin_r.cas_n) && !pin_r.ras_n && (cur_r.op == OP_READ) |-> pin_r.we_n;
  endproperty
  a_read_we: assert property (p_read_we) else $error("read with write-select low");

  property p_row_addr;
    ras_fall && pin_r.cas_n |-> (pin_r.addr == cur_r.row) ##2 (pin_r.addr == cur_r.col);
  endproperty
  a_row_addr: assert property (p_row_addr) else $error("address halves out of order");

  c_read:    cover property (vld_r && (cur_r.op == OP_READ));
  c_rmw:     cover property ($fell(pin_r.we_n) && (cur_r.op == OP_RMW));
  c_page:    cover property (st_r == S_CP);
  c_refresh: cover property (cbr_fall && init_done_o);
  c_test:    cover property (st_r == S_CPT);

endmodule

`default_nettype wire

// ==== verilog/pmdct_pkg.sv ====
package pmdct_pkg;

  typedef logic [9:0] pmdct_cyc_t;
  typedef logic [4:0] pmdct_ph_t;

  localparam int CLK_NS = 10;

  function automatic int cyc_min(input int ns);
    return (ns + CLK_NS - 1) / CLK_NS;
  endfunction

  function automatic int cyc_max(input int ns);
    return (ns / CLK_NS < 1) ? 1 : ns / CLK_NS;
  endfunction

  function automatic int imax(input int a, input int b);
    return (a > b) ? a : b;
  endfunction

  // Pin timing, nanoseconds
  localparam int ROW_ADDR_HOLD_NS              = 15;
  localparam int ROW_TO_COLUMN_DELAY_NS        = 25;
  localparam int ROW_ACCESS_TIME_NS            = 100;
  localparam int COLUMN_ACCESS_TIME_NS         = 50;
  localparam int COLUMN_PULSE_NS               = 55;
  localparam int COLUMN_TO_WRITE_DELAY_NS      = 15;
  localparam int WRITE_TO_COLUMN_LEAD_NS       = 35;
  localparam int ROW_PRECHARGE_NS              = 85;
  localparam int ROW_PULSE_NS                  = 105;
  localparam int ROW_PULSE_MAX_NS              = 10000;
  localparam int RANDOM_CYCLE_TIME_NS          = 200;
  localparam int PAGE_CYCLE_TIME_NS            = 100;
  localparam int PAGE_COLUMN_PRECHARGE_NS      = 40;
  localparam int REFRESH_COLUMN_SETUP_NS       = 20;
  localparam int REFRESH_COLUMN_HOLD_NS        = 20;
  localparam int ROW_PRECHARGE_TO_COLUMN_NS    = 20;
  localparam int COUNTER_TEST_ROW_PULSE_NS     = 230;
  localparam int COUNTER_TEST_CYCLE_TIME_NS    = 340;
  localparam int COUNTER_TEST_COL_PRECHARGE_NS = 50;
  localparam int REFRESH_PERIOD_NS             = 4000000;
  localparam int REFRESH_ROWS                  = 256;
  localparam int INIT_PAUSE_NS                 = 100000;

  // Derived cycle counts
  localparam int RCD_I = cyc_min(ROW_TO_COLUMN_DELAY_NS);
  localparam int COL_I = imax(imax(cyc_min(ROW_ACCESS_TIME_NS) - RCD_I, cyc_min(COLUMN_ACCESS_TIME_NS)),
                              cyc_min(COLUMN_PULSE_NS));
  localparam pmdct_ph_t  RAH_CYC    = pmdct_ph_t'(cyc_min(ROW_ADDR_HOLD_NS));
  localparam pmdct_ph_t  ASC_CYC    = pmdct_ph_t'(RCD_I - cyc_min(ROW_ADDR_HOLD_NS));
  localparam pmdct_ph_t  COL_CYC    = pmdct_ph_t'(COL_I);
  localparam pmdct_ph_t  CWD_CYC    = pmdct_ph_t'(cyc_min(COLUMN_TO_WRITE_DELAY_NS));
  localparam pmdct_ph_t  CWL_CYC    = pmdct_ph_t'(cyc_min(WRITE_TO_COLUMN_LEAD_NS));
  localparam pmdct_ph_t  CP_CYC     = pmdct_ph_t'(imax(cyc_min(PAGE_COLUMN_PRECHARGE_NS),
                                                       cyc_min(PAGE_CYCLE_TIME_NS) - COL_I));
  localparam pmdct_ph_t  PRE_CYC    = pmdct_ph_t'(imax(cyc_min(ROW_PRECHARGE_NS),
                                                       cyc_min(ROW_PRECHARGE_TO_COLUMN_NS)));
  localparam pmdct_ph_t  FCS_CYC    = pmdct_ph_t'(cyc_min(REFRESH_COLUMN_SETUP_NS));
  localparam pmdct_ph_t  FCH_CYC    = pmdct_ph_t'(cyc_min(REFRESH_COLUMN_HOLD_NS));
  localparam pmdct_ph_t  CPT_CYC    = pmdct_ph_t'(cyc_min(COUNTER_TEST_COL_PRECHARGE_NS));
  localparam pmdct_cyc_t RAS_CYC    = pmdct_cyc_t'(cyc_min(ROW_PULSE_NS));
  localparam pmdct_cyc_t RAS_MAX_CYC = pmdct_cyc_t'(cyc_max(ROW_PULSE_MAX_NS));
  localparam pmdct_cyc_t PAGE_LIMIT_CYC = pmdct_cyc_t'(cyc_max(ROW_PULSE_MAX_NS) - 32);
  localparam pmdct_cyc_t RC_CYC     = pmdct_cyc_t'(cyc_min(RANDOM_CYCLE_TIME_NS));
  localparam pmdct_cyc_t TRAS_CYC   = pmdct_cyc_t'(cyc_min(COUNTER_TEST_ROW_PULSE_NS));
  localparam pmdct_cyc_t RTC_CYC    = pmdct_cyc_t'(cyc_min(COUNTER_TEST_CYCLE_TIME_NS));
  localparam pmdct_cyc_t CYC_SAT    = 10'h3ff;
  localparam logic [10:0] REF_INT_CYC = 11'(cyc_max(REFRESH_PERIOD_NS / REFRESH_ROWS));
  localparam logic [13:0] INIT_PAUSE_DEF_CYC = 14'(cyc_min(INIT_PAUSE_NS));
  localparam logic [3:0]  INIT_RAS_CNT = 4'h8;

  typedef enum logic [1:0] {
    OP_READ  = 2'b00,
    OP_WRITE = 2'b01,
    OP_RMW   = 2'b10,
    OP_TEST  = 2'b11
  } pmdct_op_e;

  typedef enum logic [3:0] {
    S_INIT = 4'b0000,
    S_IDLE = 4'b0001,
    S_ROW  = 4'b0010,
    S_ASC  = 4'b0011,
    S_COL  = 4'b0100,
    S_WR   = 4'b0101,
    S_CP   = 4'b0110,
    S_RASW = 4'b0111,
    S_PRE  = 4'b1000,
    S_FCS  = 4'b1001,
    S_FCH  = 4'b1010,
    S_CPT  = 4'b1011
  } pmdct_state_e;

  typedef struct packed {
    pmdct_op_e  op;
    logic       test_wr;
    logic       page;
    logic [8:0] row;
    logic [8:0] col;
    logic       din;
  } pmdct_req_s;

  typedef struct packed {
    logic       ras_n;
    logic       cas_n;
    logic       we_n;
    logic [8:0] addr;
    logic       din;
  } pmdct_pins_s;

  localparam pmdct_pins_s PINS_IDLE = '{ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1, addr: 9'h000, din: 1'b0};

endpackage

// ==== verilog/pmdct_timer.sv ====
`timescale 1ns/1ns
`default_nettype none

module pmdct_timer #(
  parameter int             W       = 5,
  parameter logic [W-1:0]   RST_VAL = '0
) (
  // Clock and reset
  input  wire logic         mclk_i,
  input  wire logic         rst_i,
  // Control
  input  wire logic         load_i,
  input  wire logic [W-1:0] value_i,
  output logic              done_o
);

  logic [W-1:0] cnt_r;
  logic [W-1:0] cnt_nxt;

  always_comb begin
    cnt_nxt = cnt_r;
    if (load_i) begin
      cnt_nxt = value_i;
    end else if (cnt_r != '0) begin
      cnt_nxt = cnt_r - W'(1);
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_r <= RST_VAL;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  // Last cycle of a loaded span
  assign done_o = (cnt_r <= W'(1));

endmodule

`default_nettype wire
